/* File: dv/qbp_pad_model.sv */
// Board-side pad of one port: weak pull-up, device drivers, external driver.
// Assumes strong device drive always beats the board's driver.
`timescale 1ns/10ps
module qbp_pad_model
  import qbp_pkg::*;
(
  input  wire qbp_byte_t pd_in,
  input  wire qbp_byte_t oe_in,
  input  wire qbp_byte_t ext_en_in,
  input  wire qbp_byte_t ext_val_in,
  output qbp_byte_t      pin_out
);
  // Released bits follow an enabled board driver, else go to the pull-up level; never hold an old value
  assign pin_out = ~pd_in & (oe_in | ~ext_en_in | ext_val_in);
endmodule

/* File: dv/qbp_port_chk.sv */
// Checker of the port block's pin behaviour, bound to the top module.
// Assumes one clock domain with an asynchronous active-high reset.
`timescale 1ns/10ps
module qbp_port_chk
  import qbp_pkg::*;
(
  input wire logic      clk_in,
  input wire logic      rst_in,
  input wire logic      ce_in,
  input wire logic      p2_wr_in,
  input wire logic      p3_wr_in,
  input wire logic      ext_bus_active_in,
  input wire logic      ext_irq_two_rising_out,
  input wire qbp_byte_t wr_data_in,
  input wire qbp_byte_t addr_high_in,
  input wire qbp_byte_t p1_pin_in,
  input wire qbp_byte_t p1_read_out,
  input wire qbp_byte_t p2_latch_out,
  input wire qbp_byte_t p2_pd_out,
  input wire qbp_byte_t p3_latch_out,
  input wire qbp_byte_t p3_pd_out,
  input wire qbp_byte_t p3_oe_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Latches leave reset high with every strong driver off
  property p_p2_reset;
    $fell(rst_in) |-> p2_latch_out == 8'hFF && p2_pd_out == 8'h00;
  endproperty
  a_p2_reset: assert property (p_p2_reset) else $error("port two busy after reset");
  property p_p3_reset;
    $fell(rst_in) |-> p3_latch_out == 8'hFF && p3_pd_out == 8'h00 && p3_oe_out == 8'h00;
  endproperty
  a_p3_reset: assert property (p_p3_reset) else $error("port three busy after reset");
  // A written byte sets the pull-downs and they hold while nothing is written
  property p_pd_hold;
    (ce_in && p2_wr_in && !ext_bus_active_in) ##1 (ce_in && !p2_wr_in && !ext_bus_active_in)[*3]
      |-> p2_pd_out == ~$past(wr_data_in, 3);
  endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("pull-down not set by write");
  // Boost high one cycle after the latch rises, gone two cycles later
  property p_boost_on;
    ce_in && !p3_wr_in && $rose(p3_latch_out[0]) ##1 ce_in |-> p3_oe_out[0] && !p3_pd_out[0];
  endproperty
  a_boost_on: assert property (p_boost_on) else $error("no boost on rising latch");
  property p_boost_off;
    ce_in && !p3_wr_in && $rose(p3_latch_out[0]) ##1 (ce_in && !p3_wr_in)[*3] |-> !p3_oe_out[0];
  endproperty
  a_boost_off: assert property (p_boost_off) else $error("boost too long");
  // During bus cycles port two carries the high address byte
  property p_addr;
    (ce_in && ext_bus_active_in && $stable(addr_high_in))[*3] |-> p2_pd_out == ~addr_high_in;
  endproperty
  a_addr: assert property (p_addr) else $error("address byte not on port two");
  // A steady pin is what the read path returns
  property p_read;
    (ce_in && $stable(p1_pin_in))[*7] |-> p1_read_out == p1_pin_in;
  endproperty
  a_read: assert property (p_read) else $error("read level differs from pin");
  property p_irq2;
    ce_in && $rose(p1_read_out[4]) |-> ##[0:2] ext_irq_two_rising_out;
  endproperty
  a_irq2: assert property (p_irq2) else $error("rising edge not flagged");
  c_boost: cover property ($rose(p3_latch_out[0]));
  c_bus: cover property (ext_bus_active_in [*3]);
  c_irq: cover property (ext_irq_two_rising_out);
endmodule

bind qbp_port_top qbp_port_chk i_chk (.clk_in, .rst_in, .ce_in, .p2_wr_in, .p3_wr_in,
  .ext_bus_active_in, .ext_irq_two_rising_out, .wr_data_in, .addr_high_in, .p1_pin_in,
  .p1_read_out, .p2_latch_out, .p2_pd_out, .p3_latch_out, .p3_pd_out, .p3_oe_out);

/* File: dv/quasi_bidir_port_with_alt_mux_bench.sv */
// Self-checking bench of the port block with pad models on ports one to three.
// Assumes the package, the top module, its checker and the pad model are compiled.
`timescale 1ns/10ps
module quasi_bidir_port_with_alt_mux_bench
  import qbp_pkg::*;
;
  logic      clk_in, rst_in, ce_in, p1_wr_in, p2_wr_in, p3_wr_in, ext_bus_active_in;
  logic      timer2_ext_io_drive_in, serial1_transmit_in, serial0_transmit_in;
  logic      wr_strobe_n_in, rd_strobe_n_in, strobe_active_in, program_memory_select_in;
  logic      load_sel_wr_in, load_sel_data_in, fetch_external_out, timer2_ext_io_out;
  logic      timer2_capture_reload_trigger_out, serial1_receive_pin_out, ext_irq_zero_out;
  logic      ext_irq_two_rising_out, ext_irq_three_falling_out, ext_irq_four_rising_out;
  logic      ext_irq_five_falling_out, serial0_receive_pin_out, ext_irq_one_out;
  logic      timer_zero_ext_input_out, timer_one_ext_input_out;
  qbp_byte_t wr_data_in, addr_high_in, p1_pin_in, p2_pin_in, p3_pin_in, p1_pd_out, p2_pd_out;
  qbp_byte_t p3_pd_out, p1_oe_out, p2_oe_out, p3_oe_out, p1_read_out, p2_read_out;
  qbp_byte_t p3_read_out, p1_latch_out, p2_latch_out, p3_latch_out, v1, v3, l2, l3, e1, e3, pr;
  qbp_load_t crystal_load_out;
  logic [3:0]  hit;
  logic [31:0] r;
  int        err_count, n_tests;

  qbp_port_top i_dut (.*);
  // The board drives ports one and three; port two only has its pull-up
  qbp_pad_model i_pad1 (.pd_in(p1_pd_out), .oe_in(p1_oe_out), .ext_en_in(8'hFF),
    .ext_val_in(v1), .pin_out(p1_pin_in));
  qbp_pad_model i_pad2 (.pd_in(p2_pd_out), .oe_in(p2_oe_out), .ext_en_in(8'h00),
    .ext_val_in(8'h00), .pin_out(p2_pin_in));
  qbp_pad_model i_pad3 (.pd_in(p3_pd_out), .oe_in(p3_oe_out), .ext_en_in(8'hFF),
    .ext_val_in(v3), .pin_out(p3_pin_in));

  always #4 clk_in = ~clk_in;

  // Expected latch-and-alternate value of ports one and three
  function automatic qbp_byte_t eff1(input logic t2, input logic tx);
    return {4'hF, tx, 2'b11, t2};
  endfunction
  function automatic qbp_byte_t eff3(input qbp_byte_t l, input logic tx, sa, wn, rn);
    return l & {~sa | rn, ~sa | wn, 4'hF, tx, 1'b1};
  endfunction
  function automatic logic [3:0] irq_exp(input qbp_byte_t a, input qbp_byte_t b);
    return {a[7] & ~b[7], ~a[6] & b[6], a[5] & ~b[5], ~a[4] & b[4]};
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic neg(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // One-cycle latch write; returns at the edge that takes it
  task automatic wr(input int p, input qbp_byte_t d);
    @(posedge clk_in);
    p1_wr_in <= (p == 1);
    p2_wr_in <= (p == 2);
    p3_wr_in <= (p == 3);
    wr_data_in <= d;
    @(posedge clk_in);
    {p1_wr_in, p2_wr_in, p3_wr_in} <= 3'b000;
  endtask

  // Run takes about 700 cycles; the limit leaves a wide margin
  initial begin
    #100us;
    err_count++;
    close_out();
  end

  initial begin
    clk_in = 1'b0;
    rst_in = 1'b1;
    ce_in = 1'b1;
    {p1_wr_in, p2_wr_in, p3_wr_in, ext_bus_active_in, load_sel_wr_in, load_sel_data_in} = '0;
    {timer2_ext_io_drive_in, serial1_transmit_in, serial0_transmit_in} = 3'b111;
    {wr_strobe_n_in, rd_strobe_n_in, strobe_active_in, program_memory_select_in} = 4'b1101;
    {wr_data_in, addr_high_in, v1, v3} = {4{8'hFF}};
    void'($urandom(51));
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    neg(1);
    check(p2_latch_out, 8'hFF);
    check(p3_latch_out, 8'hFF);
    // Clock enable low freezes the latch, so this write must be lost
    @(posedge clk_in);
    ce_in <= 1'b0;
    wr(1, 8'h00);
    neg(3);
    check(p1_latch_out, 8'hFF);
    check(p1_pd_out, 8'h00);
    @(posedge clk_in);
    ce_in <= 1'b1;
    // Zero write, then the boost walk back to the weak high
    wr(1, 8'h00);
    neg(8);
    check(p1_pd_out, 8'hFF);
    check(p1_read_out, 8'h00);
    wr(1, 8'hFF);
    neg(3);
    check(p1_oe_out & ~p1_pd_out, 8'hFF);
    neg(1);
    check(p1_oe_out, 8'hFF);
    neg(1);
    check(p1_oe_out, 8'h00);
    // A cleared latch bit overrides a high alternate output
    wr(1, 8'hF7);
    neg(4);
    check(p1_pd_out, 8'h08);
    check(p1_latch_out, 8'hF7);
    wr(1, 8'hFF);
    // Both load codes and both strap levels
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_in);
      load_sel_wr_in <= 1'b1;
      load_sel_data_in <= ~i[0];
      program_memory_select_in <= i[0];
      @(posedge clk_in);
      load_sel_wr_in <= 1'b0;
      neg(10);
      check({6'h0, crystal_load_out}, {6'h0, i ? QBP_LOAD_SIX : QBP_LOAD_TWELVE});
      check({7'h0, fetch_external_out}, {7'h0, ~i[0]});
    end
    pr = 8'hFF;
    for (int i = 0; i < 40; i++) begin
      r = $urandom();
      l2 = r[7:0];
      l3 = r[15:8];
      wr(2, l2);
      wr(3, l3);
      r = $urandom();
      @(posedge clk_in);
      {timer2_ext_io_drive_in, serial1_transmit_in, serial0_transmit_in} <= r[2:0];
      {strobe_active_in, wr_strobe_n_in, rd_strobe_n_in, ext_bus_active_in} <= r[6:3];
      addr_high_in <= r[15:8];
      v1 <= r[23:16];
      v3 <= r[31:24];
      hit = 4'h0;
      repeat (12) begin
        @(negedge clk_in);
        hit |= {ext_irq_five_falling_out, ext_irq_four_rising_out,
                ext_irq_three_falling_out, ext_irq_two_rising_out};
      end
      e1 = eff1(timer2_ext_io_drive_in, serial1_transmit_in);
      e3 = eff3(l3, serial0_transmit_in, strobe_active_in, wr_strobe_n_in, rd_strobe_n_in);
      check(p1_pd_out, ~e1);
      check(p2_pd_out, ext_bus_active_in ? ~addr_high_in : ~l2);
      check(p2_oe_out, ext_bus_active_in ? ~addr_high_in : ~l2);
      check(p2_read_out, ext_bus_active_in ? addr_high_in : l2);
      check(p3_latch_out, l3);
      check(p3_pd_out, ~e3);
      check(p1_read_out, v1 & e1);
      check(p3_read_out, v3 & e3);
      check({4'h0, hit}, {4'h0, irq_exp(pr, v1 & e1)});
      check({5'h0, serial1_receive_pin_out, timer2_capture_reload_trigger_out,
             timer2_ext_io_out}, {5'h0, v1[2:0] & e1[2:0]});
      check({2'h0, timer_one_ext_input_out, timer_zero_ext_input_out, ext_irq_one_out,
             ext_irq_zero_out, 1'b0, serial0_receive_pin_out}, v3 & e3 & 8'h3D);
      pr = v1 & e1;
    end
    // Reset in mid-run drops a held pull-down; leave bus mode so the latch, not the address byte, drives the pull-downs
    @(posedge clk_in);
    ext_bus_active_in <= 1'b0;
    wr(2, 8'h00);
    neg(3);
    check(p2_pd_out, 8'hFF);
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    neg(1);
    check(p2_latch_out, 8'hFF);
    check(p2_pd_out, 8'h00);
    close_out();
  end
endmodule

/* File: pkg/qbp_defs.svh */
// Constants for the quasi-bidirectional port block: reset values, bit positions, timing.
// Assumes inclusion by bare name from the package and design files.
`ifndef QBP_DEFS_SVH
`define QBP_DEFS_SVH
`define QBP_LATCH_RESET     8'hFF
`define QBP_P1_T2_IO        0
`define QBP_P1_T2_TRIG      1
`define QBP_P1_SER1_RX      2
`define QBP_P1_SER1_TX      3
`define QBP_P1_IRQ2         4
`define QBP_P1_IRQ3         5
`define QBP_P1_IRQ4         6
`define QBP_P1_IRQ5         7
`define QBP_P3_SER0_RX      0
`define QBP_P3_SER0_TX      1
`define QBP_P3_IRQ0         2
`define QBP_P3_IRQ1         3
`define QBP_P3_TMR0         4
`define QBP_P3_TMR1         5
`define QBP_P3_WR_STROBE    6
`define QBP_P3_RD_STROBE    7
`define QBP_BOOST_NS        16
`define QBP_CLK_PERIOD_NS   8
`define QBP_BOOST_CYCLES    ((`QBP_BOOST_NS + `QBP_CLK_PERIOD_NS - 1) / `QBP_CLK_PERIOD_NS)
`endif

/* File: pkg/qbp_pkg.sv */
// Types shared by the quasi-bidirectional port block.
// Assumes the constants header is on the include path.
package qbp_pkg;
  `include "qbp_defs.svh"
  typedef logic [7:0] qbp_byte_t;
  typedef enum logic [1:0] {
    QBP_LOAD_SIX    = 2'b01,
    QBP_LOAD_TWELVE = 2'b10
  } qbp_load_t;
endpackage

/* File: rtl/qbp_pin_cell.sv */
// One port of eight quasi-bidirectional pin cells with input synchronisers.
// Assumes a single clock; pad resolution lives outside with a weak pull-up.
`timescale 1ns/10ps
`include "qbp_defs.svh"
module qbp_pin_cell
  import qbp_pkg::*;
(
  input  wire logic      clk_in,
  input  wire logic      rst_in,
  input  wire logic      ce_in,
  input  wire qbp_byte_t latch_in,
  input  wire qbp_byte_t pin_in,
  output qbp_byte_t      pull_down_out,
  output qbp_byte_t      boost_out,
  output qbp_byte_t      level_out
);
  localparam int BW = 4;
  localparam logic [BW-1:0] BOOST_CNT = BW'(`QBP_BOOST_CYCLES);

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      logic          prev_q;
      logic [BW-1:0] cnt_q;
      logic [2:0]    sync_q;
      logic          lvl_q;

      // Strong pull-down follows a zero latch and stays until a one lands
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          pull_down_out[i] <= 1'b0;
          prev_q           <= 1'b1;
        end else if (ce_in) begin
          pull_down_out[i] <= ~latch_in[i];
          prev_q           <= latch_in[i];
        end
      end

      // Brief strong high drive on a rising latch, then weak pull-up only
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          cnt_q        <= '0;
          boost_out[i] <= 1'b0;
        end else if (ce_in) begin
          if (latch_in[i] && !prev_q) begin
            cnt_q        <= BOOST_CNT - 4'h1;
            boost_out[i] <= 1'b1;
          end else if (cnt_q != '0) begin
            cnt_q        <= cnt_q - 4'h1;
          end else begin
            boost_out[i] <= 1'b0;
          end
          if (!latch_in[i]) begin
            boost_out[i] <= 1'b0;
            cnt_q        <= '0;
          end
        end
      end

      // Three-stage sync; a level only counts when stages two and three agree
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          sync_q <= 3'h7;
          lvl_q  <= 1'b1;
        end else if (ce_in) begin
          sync_q <= {sync_q[1:0], pin_in[i]};
          if (sync_q[1] == sync_q[2]) begin
            lvl_q <= sync_q[2];
          end
        end
      end
      assign level_out[i] = lvl_q;
    end
  endgenerate
endmodule

/* File: rtl/qbp_port_top.sv */
// Port one, two and three pin logic with alternate-function muxing.
// Assumes core peripherals drive the alt outputs and pads add weak pull-ups.
`timescale 1ns/10ps
`include "qbp_defs.svh"
module qbp_port_top
  import qbp_pkg::*;
(
  input  wire logic      clk_in,
  input  wire logic      rst_in,
  input  wire logic      ce_in,
  // Software latch writes
  input  wire logic      p1_wr_in,
  input  wire logic      p2_wr_in,
  input  wire logic      p3_wr_in,
  input  wire qbp_byte_t wr_data_in,
  // Pads
  input  wire qbp_byte_t p1_pin_in,
  input  wire qbp_byte_t p2_pin_in,
  input  wire qbp_byte_t p3_pin_in,
  output qbp_byte_t      p1_pd_out,
  output qbp_byte_t      p2_pd_out,
  output qbp_byte_t      p3_pd_out,
  output qbp_byte_t      p1_oe_out,
  output qbp_byte_t      p2_oe_out,
  output qbp_byte_t      p3_oe_out,
  output qbp_byte_t      p1_read_out,
  output qbp_byte_t      p2_read_out,
  output qbp_byte_t      p3_read_out,
  output qbp_byte_t      p1_latch_out,
  output qbp_byte_t      p2_latch_out,
  output qbp_byte_t      p3_latch_out,
  // External bus
  input  wire logic      ext_bus_active_in,
  input  wire qbp_byte_t addr_high_in,
  // Alternate outputs from peripherals
  input  wire logic      timer2_ext_io_drive_in,
  input  wire logic      serial1_transmit_in,
  input  wire logic      serial0_transmit_in,
  input  wire logic      wr_strobe_n_in,
  input  wire logic      rd_strobe_n_in,
  input  wire logic      strobe_active_in,
  // Alternate inputs to peripherals
  output logic           timer2_ext_io_out,
  output logic           timer2_capture_reload_trigger_out,
  output logic           serial1_receive_pin_out,
  output logic           ext_irq_two_rising_out,
  output logic           ext_irq_three_falling_out,
  output logic           ext_irq_four_rising_out,
  output logic           ext_irq_five_falling_out,
  output logic           serial0_receive_pin_out,
  output logic           ext_irq_zero_out,
  output logic           ext_irq_one_out,
  output logic           timer_zero_ext_input_out,
  output logic           timer_one_ext_input_out,
  // Memory select and timekeeping load
  input  wire logic      program_memory_select_in,
  output logic           fetch_external_out,
  input  wire logic      load_sel_wr_in,
  input  wire logic      load_sel_data_in,
  output qbp_load_t      crystal_load_out
);
  qbp_byte_t p1_q, p2_q, p3_q;
  qbp_byte_t p1_pd, p2_pd, p3_pd;
  qbp_byte_t p1_bst, p2_bst, p3_bst;
  qbp_byte_t p1_lvl, p2_lvl, p3_lvl;
  qbp_byte_t p1_eff, p2_eff, p3_eff;
  qbp_byte_t p1_prev_q;
  logic [2:0] ms_sync_q;

  // Port latches start high so pins idle on the weak pull-up
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      p1_q <= `QBP_LATCH_RESET;
      p2_q <= `QBP_LATCH_RESET;
      p3_q <= `QBP_LATCH_RESET;
    end else if (ce_in) begin
      if (p1_wr_in) begin
        p1_q <= wr_data_in;
      end
      if (p2_wr_in) begin
        p2_q <= wr_data_in;
      end
      if (p3_wr_in) begin
        p3_q <= wr_data_in;
      end
    end
  end

  // Alternate outputs on ports one and three are ANDed with the latch so a zero latch still wins; on port two the address byte replaces the latch
  always_comb begin
    p1_eff = p1_q;
    p1_eff[`QBP_P1_T2_IO]   = p1_q[`QBP_P1_T2_IO] & timer2_ext_io_drive_in;
    p1_eff[`QBP_P1_SER1_TX] = p1_q[`QBP_P1_SER1_TX] & serial1_transmit_in;
    p2_eff = ext_bus_active_in ? addr_high_in : p2_q;
    p3_eff = p3_q;
    p3_eff[`QBP_P3_SER0_TX] = p3_q[`QBP_P3_SER0_TX] & serial0_transmit_in;
    p3_eff[`QBP_P3_WR_STROBE] = p3_q[`QBP_P3_WR_STROBE]
                              & (strobe_active_in ? wr_strobe_n_in : 1'b1);
    p3_eff[`QBP_P3_RD_STROBE] = p3_q[`QBP_P3_RD_STROBE]
                              & (strobe_active_in ? rd_strobe_n_in : 1'b1);
  end

  qbp_pin_cell u_p1 (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .ce_in         (ce_in),
    .latch_in      (p1_eff),
    .pin_in        (p1_pin_in),
    .pull_down_out (p1_pd),
    .boost_out     (p1_bst),
    .level_out     (p1_lvl)
  );
  qbp_pin_cell u_p2 (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .ce_in         (ce_in),
    .latch_in      (p2_eff),
    .pin_in        (p2_pin_in),
    .pull_down_out (p2_pd),
    .boost_out     (p2_bst),
    .level_out     (p2_lvl)
  );
  qbp_pin_cell u_p3 (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .ce_in         (ce_in),
    .latch_in      (p3_eff),
    .pin_in        (p3_pin_in),
    .pull_down_out (p3_pd),
    .boost_out     (p3_bst),
    .level_out     (p3_lvl)
  );

  // Register pad controls so every output leaves a flip-flop
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      p1_pd_out    <= 8'h00;
      p2_pd_out    <= 8'h00;
      p3_pd_out    <= 8'h00;
      p1_oe_out    <= 8'h00;
      p2_oe_out    <= 8'h00;
      p3_oe_out    <= 8'h00;
      p1_read_out  <= 8'hFF;
      p2_read_out  <= 8'hFF;
      p3_read_out  <= 8'hFF;
      p1_latch_out <= 8'hFF;
      p2_latch_out <= 8'hFF;
      p3_latch_out <= 8'hFF;
    end else if (ce_in) begin
      p1_pd_out    <= p1_pd;
      p2_pd_out    <= p2_pd;
      p3_pd_out    <= p3_pd;
      p1_oe_out    <= p1_pd | p1_bst;
      p2_oe_out    <= p2_pd | p2_bst;
      p3_oe_out    <= p3_pd | p3_bst;
      p1_read_out  <= p1_lvl;
      p2_read_out  <= p2_lvl;
      p3_read_out  <= p3_lvl;
      p1_latch_out <= p1_q;
      p2_latch_out <= p2_q;
      p3_latch_out <= p3_q;
    end
  end

  // Alternate inputs; edge-type interrupts flag for one cycle on their edge
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      p1_prev_q                         <= 8'hFF;
      timer2_ext_io_out                 <= 1'b1;
      timer2_capture_reload_trigger_out <= 1'b1;
      serial1_receive_pin_out           <= 1'b1;
      ext_irq_two_rising_out            <= 1'b0;
      ext_irq_three_falling_out         <= 1'b0;
      ext_irq_four_rising_out           <= 1'b0;
      ext_irq_five_falling_out          <= 1'b0;
      serial0_receive_pin_out           <= 1'b1;
      ext_irq_zero_out                  <= 1'b1;
      ext_irq_one_out                   <= 1'b1;
      timer_zero_ext_input_out          <= 1'b1;
      timer_one_ext_input_out           <= 1'b1;
    end else if (ce_in) begin
      p1_prev_q                         <= p1_lvl;
      timer2_ext_io_out                 <= p1_lvl[`QBP_P1_T2_IO];
      timer2_capture_reload_trigger_out <= p1_lvl[`QBP_P1_T2_TRIG];
      serial1_receive_pin_out           <= p1_lvl[`QBP_P1_SER1_RX];
      ext_irq_two_rising_out    <= p1_lvl[`QBP_P1_IRQ2] & ~p1_prev_q[`QBP_P1_IRQ2];
      ext_irq_three_falling_out <= ~p1_lvl[`QBP_P1_IRQ3] & p1_prev_q[`QBP_P1_IRQ3];
      ext_irq_four_rising_out   <= p1_lvl[`QBP_P1_IRQ4] & ~p1_prev_q[`QBP_P1_IRQ4];
      ext_irq_five_falling_out  <= ~p1_lvl[`QBP_P1_IRQ5] & p1_prev_q[`QBP_P1_IRQ5];
      serial0_receive_pin_out           <= p3_lvl[`QBP_P3_SER0_RX];
      ext_irq_zero_out                  <= p3_lvl[`QBP_P3_IRQ0];
      ext_irq_one_out                   <= p3_lvl[`QBP_P3_IRQ1];
      timer_zero_ext_input_out          <= p3_lvl[`QBP_P3_TMR0];
      timer_one_ext_input_out           <= p3_lvl[`QBP_P3_TMR1];
    end
  end

  // Strap is board-tied; synchronised anyway since it is an async pin
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ms_sync_q          <= 3'h0;
      fetch_external_out <= 1'b1;
    end else if (ce_in) begin
      ms_sync_q <= {ms_sync_q[1:0], program_memory_select_in};
      if (ms_sync_q[1] == ms_sync_q[2]) begin
        fetch_external_out <= ~ms_sync_q[2];
      end
    end
  end

  // Crystal load selection, six picofarad by default
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      crystal_load_out <= QBP_LOAD_SIX;
    end else if (ce_in && load_sel_wr_in) begin
      crystal_load_out <= load_sel_data_in ? QBP_LOAD_TWELVE : QBP_LOAD_SIX;
    end
  end
endmodule
